// ==== hdl/etsr_pkg.sv ====
// etsr_pkg: offsets, field positions, reset values and codes for the
// event timestamp sample readout block.
// assumes: 32-bit register words addressed by byte offset.
package etsr_pkg;
  localparam logic [15:0] OFF_S7_PHASE   = 16'h05a4;
  localparam logic [15:0] OFF_S8_NSEDGE  = 16'h05a8;
  localparam logic [15:0] OFF_S8_SECONDS = 16'h05ac;
  localparam logic [15:0] OFF_S8_PHASE   = 16'h05b0;
  localparam logic [15:0] OFF_UNIT_INDEX = 16'h0000;

  localparam int EDGE_BIT      = 30;
  localparam int NS_MSB        = 29;
  localparam int UNIT_PTR_BIT  = 8;
  localparam int NUM_UNITS     = 2;
  localparam int SLOT_NS       = 8;
  localparam int SLOTS_PER_REF = 5;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    ETSR_SLOT_0NS  = 3'h0,
    ETSR_SLOT_8NS  = 3'h1,
    ETSR_SLOT_16NS = 3'h2,
    ETSR_SLOT_24NS = 3'h3,
    ETSR_SLOT_32NS = 3'h4
  } etsr_slot_e;
endpackage : etsr_pkg

// ==== hdl/etsr_cap_if.sv ====
// etsr_cap_if: one captured sample travelling to a sample slot.
// assumes: single clock domain, capture strobe one cycle wide.
`timescale 1ns/1ps
`default_nettype none
interface etsr_cap_if;
  logic        load;
  logic [31:0] seconds;
  logic [29:0] nanoseconds;
  logic        rising;
  logic [2:0]  slot;
  modport src (output load, seconds, nanoseconds, rising, slot);
  modport dst (input load, seconds, nanoseconds, rising, slot);
endinterface : etsr_cap_if
`default_nettype wire

// ==== hdl/etsr_sample_slot.sv ====
// etsr_sample_slot: holds one captured sample, loaded as a whole.
// assumes: load from etsr_cap_if on mclk, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module etsr_sample_slot (
  input  wire logic        mclk,
  input  wire logic        srst,
  etsr_cap_if.dst          cap,
  output logic [31:0]      nsWord,
  output logic [31:0]      secWord,
  output logic [31:0]      phaseWord
);
  logic [31:0] sec_r;
  logic [29:0] ns_r;
  logic        edge_r;
  logic [2:0]  slot_r;

  // all fields change on the same edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      sec_r  <= etsr_pkg::RESET_WORD;
      ns_r   <= '0;
      edge_r <= 1'b0;
      slot_r <= etsr_pkg::ETSR_SLOT_0NS;
    end else if (cap.load) begin
      sec_r  <= cap.seconds;
      ns_r   <= cap.nanoseconds;
      edge_r <= cap.rising;
      slot_r <= cap.slot;
    end
  end

  assign nsWord    = {1'b0, edge_r, ns_r};
  assign secWord   = sec_r;
  assign phaseWord = {29'h0000_0000, slot_r};

  slot_legal_a: assert property (@(posedge mclk) disable iff (srst)
    slot_r <= 3'h4) else $error("phase slot code reserved");
  load_whole_a: assert property (@(posedge mclk) disable iff (srst)
    cap.load |=> (sec_r == $past(cap.seconds)) &&
                 (ns_r == $past(cap.nanoseconds)) &&
                 (edge_r == $past(cap.rising)) &&
                 (slot_r == $past(cap.slot)))
    else $error("sample fields not loaded together");
endmodule : etsr_sample_slot
`default_nettype wire

// ==== hdl/etsr_readout.sv ====
// etsr_readout: seventh and eighth event timestamp sample registers,
// two timestamp units selected by the unit index pointer.
// assumes: capture logic supplies time and 250 MHz cycle phase; the edge
// is taken from the event pin, synchronised here with three flops.
`timescale 1ns/1ps
`default_nettype none
module etsr_readout (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [1:0]  eventPin,
  input  wire logic [1:0]  eventEnable,
  input  wire logic [1:0]  captureToSeventh,
  input  wire logic [31:0] timeSeconds,
  input  wire logic [29:0] timeNanoseconds,
  input  wire logic [3:0]  refPhase,
  input  wire logic        regRead,
  input  wire logic        regWrite,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWdata,
  output logic [31:0]      regRdata
);
  // ******************************
  // unit index pointer
  // ******************************
  logic        unitSel_r;
  logic        unitSel_nxt;
  logic        idxHit;
  logic [31:0] idxWord;

  assign idxHit      = regWrite && (regAddr == etsr_pkg::OFF_UNIT_INDEX);
  assign unitSel_nxt = idxHit ? regWdata[etsr_pkg::UNIT_PTR_BIT]
                              : unitSel_r;
  // only the pointer bit reads back; the rest of the word is zero
  assign idxWord     = 32'(unitSel_r) << etsr_pkg::UNIT_PTR_BIT;

  always_ff @(posedge mclk) begin
    if (srst) begin
      unitSel_r <= 1'b0;
    end else begin
      unitSel_r <= unitSel_nxt;
    end
  end

  index_ptr_a: assert property (@(posedge mclk) disable iff (srst)
    idxHit |=> unitSel_r == $past(regWdata[etsr_pkg::UNIT_PTR_BIT]))
    else $error("unit pointer not taken from index write");
  index_hold_a: assert property (@(posedge mclk) disable iff (srst)
    !idxHit |=> $stable(unitSel_r))
    else $error("unit pointer moved without index write");

  // ******************************
  // reference phase slot
  // ******************************
  // refPhase counts 4 ns ticks 0..9 within 40 ns; two ticks per slot
  logic [3:0] tickPair;
  logic [2:0] slotCode;

  assign tickPair = refPhase >> 1;
  // ticks 8 and 9, and any count past them, fall in the last slot
  assign slotCode = (tickPair == 4'h0) ? etsr_pkg::ETSR_SLOT_0NS  :
                    (tickPair == 4'h1) ? etsr_pkg::ETSR_SLOT_8NS  :
                    (tickPair == 4'h2) ? etsr_pkg::ETSR_SLOT_16NS :
                    (tickPair == 4'h3) ? etsr_pkg::ETSR_SLOT_24NS :
                                         etsr_pkg::ETSR_SLOT_32NS;

  slot_16ns_a: assert property (@(posedge mclk) disable iff (srst)
    (refPhase[3:1] == 3'h2) |-> (slotCode == etsr_pkg::ETSR_SLOT_16NS))
    else $error("16 ns slot code wrong");
  slot_32ns_a: assert property (@(posedge mclk) disable iff (srst)
    (refPhase >= 4'h8) |-> (slotCode == etsr_pkg::ETSR_SLOT_32NS))
    else $error("32 ns slot code wrong");
  slot_range_a: assert property (@(posedge mclk) disable iff (srst)
    slotCode <= 3'h4)
    else $error("reserved phase code decoded");

  // ******************************
  // per-unit capture and slots
  // ******************************
  logic [31:0] nsW  [etsr_pkg::NUM_UNITS][2];
  logic [31:0] secW [etsr_pkg::NUM_UNITS][2];
  logic [31:0] phW  [etsr_pkg::NUM_UNITS][2];

  genvar u;
  genvar k;
  generate
    for (u = 0; u < etsr_pkg::NUM_UNITS; u++) begin : g_unit
      logic [2:0] sync_r;
      logic       last_r;
      logic       settled;
      logic       changed;
      logic       take;
      logic       loadSeventh;
      logic       loadEighth;

      // three flops; a level counts once the second and third agree
      always_ff @(posedge mclk) begin
        if (srst) begin
          sync_r <= 3'h0;
          last_r <= 1'b0;
        end else begin
          sync_r <= {sync_r[1:0], eventPin[u]};
          if (settled) begin
            last_r <= sync_r[2];
          end
        end
      end

      assign settled     = sync_r[1] == sync_r[2];
      assign changed     = settled && (sync_r[2] != last_r);
      assign take        = changed && eventEnable[u];
      assign loadSeventh = take && captureToSeventh[u];
      assign loadEighth  = take && !captureToSeventh[u];

      // polarity is the settled level, three edges after the pin moved
      take_polar_a: assert property (@(posedge mclk) disable iff (srst)
        take |-> (sync_r[2] == $past(eventPin[u], 3)))
        else $error("edge polarity does not follow the pin");
      take_once_a: assert property (@(posedge mclk) disable iff (srst)
        take |=> !take)
        else $error("one pin transition captured twice");

      for (k = 0; k < 2; k++) begin : g_slot
        etsr_cap_if capIf ();
        assign capIf.load        = (k == 0) ? loadSeventh : loadEighth;
        assign capIf.seconds     = timeSeconds;
        assign capIf.nanoseconds = timeNanoseconds;
        assign capIf.rising      = sync_r[2];
        assign capIf.slot        = slotCode;
        etsr_sample_slot u_slot (
          .mclk      (mclk),
          .srst      (srst),
          .cap       (capIf.dst),
          .nsWord    (nsW[u][k]),
          .secWord   (secW[u][k]),
          .phaseWord (phW[u][k])
        );
      end
    end
  endgenerate

  // ******************************
  // read decode
  // ******************************
  logic        hitIndex;
  logic        hitS7Phase;
  logic        hitS8Ns;
  logic        hitS8Sec;
  logic        hitS8Phase;
  logic        anyHit;
  logic [31:0] selNs;
  logic [31:0] selSec;
  logic [31:0] selS7Phase;
  logic [31:0] selS8Phase;
  logic [31:0] rdSel;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  assign hitIndex   = regAddr == etsr_pkg::OFF_UNIT_INDEX;
  assign hitS7Phase = regAddr == etsr_pkg::OFF_S7_PHASE;
  assign hitS8Ns    = regAddr == etsr_pkg::OFF_S8_NSEDGE;
  assign hitS8Sec   = regAddr == etsr_pkg::OFF_S8_SECONDS;
  assign hitS8Phase = regAddr == etsr_pkg::OFF_S8_PHASE;
  assign anyHit     = hitIndex || hitS7Phase || hitS8Ns || hitS8Sec ||
                      hitS8Phase;

  // sample words of the unit that the pointer names
  assign selNs      = nsW[unitSel_r][1];
  assign selSec     = secW[unitSel_r][1];
  assign selS7Phase = phW[unitSel_r][0];
  assign selS8Phase = phW[unitSel_r][1];

  // unmapped offsets read as zero
  assign rdSel = hitIndex   ? idxWord    :
                 hitS7Phase ? selS7Phase :
                 hitS8Ns    ? selNs      :
                 hitS8Sec   ? selSec     :
                 hitS8Phase ? selS8Phase :
                              etsr_pkg::RESET_WORD;
  // read data stands until the next read strobe
  assign rdata_nxt = regRead ? rdSel : rdata_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_r <= etsr_pkg::RESET_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign regRdata = rdata_r;

  // ******************************
  // readout checks
  // ******************************
  rsvd_zero_a: assert property (@(posedge mclk) disable iff (srst)
    (regRead && hitS8Ns) |=> !regRdata[31])
    else $error("reserved ns bit 31 set");
  unit_select_a: assert property (@(posedge mclk) disable iff (srst)
    (regRead && hitS8Sec) |=> (regRdata == $past(secW[unitSel_r][1])))
    else $error("seconds read from wrong unit");
  phase_read_a: assert property (@(posedge mclk) disable iff (srst)
    (regRead && hitS8Phase)
      |=> (regRdata[31:3] == 29'h0) && (regRdata[2:0] <= 3'h4))
    else $error("phase word reserved value");
  rd_hold_a: assert property (@(posedge mclk) disable iff (srst)
    !regRead |=> $stable(regRdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (@(posedge mclk) disable iff (srst)
    (regRead && !anyHit) |=> (regRdata == etsr_pkg::RESET_WORD))
    else $error("unmapped offset read not zero");
  reset_zero_a: assert property (@(posedge mclk) srst |=>
    (secW[0][1] == etsr_pkg::RESET_WORD) &&
    (secW[1][1] == etsr_pkg::RESET_WORD) &&
    (regRdata == etsr_pkg::RESET_WORD))
    else $error("seconds or read data not zero after reset");
endmodule : etsr_readout
`default_nettype wire

// ==== dv/etsr_event_src.sv ====
// etsr_event_src: event input pins seen by the readout block.
// assumes: the bench calls setPin; pins idle low after time zero.
`timescale 1ns/1ps
`default_nettype none
module etsr_event_src (
  input  wire logic       mclk,
  output var  logic [1:0] eventPin
);
  initial eventPin = 2'h0;
  // pins move on the falling edge only
  task automatic setPin(input int unit, input logic lvl);
    @(negedge mclk);
    eventPin[unit] = lvl;
  endtask : setPin
endmodule : etsr_event_src
`default_nettype wire

// ==== dv/etsr_readout_test.sv ====
// etsr_readout_test: captures on two units, then register readback.
// assumes: etsr_readout and etsr_event_src compiled before.
`timescale 1ns/1ps
`default_nettype none
module etsr_readout_test;
  // ****************
  // bench
  // ****************
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [1:0]  eventPin;
  logic [1:0]  eventEnable = 2'h3;
  logic [1:0]  captureToSeventh = 2'h0;
  logic [31:0] timeSeconds = 32'h0000_0000;
  logic [29:0] timeNanoseconds = 30'h0000_0000;
  logic [3:0]  refPhase = 4'h0;
  logic        regRead = 1'b0;
  logic        regWrite = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [31:0] regRdata;
  logic [31:0] e7p [2] = '{default: 32'h0000_0000};
  logic [31:0] e8n [2] = '{default: 32'h0000_0000};
  logic [31:0] e8s [2] = '{default: 32'h0000_0000};
  logic [31:0] e8p [2] = '{default: 32'h0000_0000};
  int          fails = 0;
  int          checked = 0;
  always #2 mclk = ~mclk;
  etsr_event_src i_src (.mclk(mclk), .eventPin(eventPin));
  etsr_readout i_dut (.mclk(mclk), .srst(srst), .eventPin(eventPin),
    .eventEnable(eventEnable), .captureToSeventh(captureToSeventh),
    .timeSeconds(timeSeconds), .timeNanoseconds(timeNanoseconds),
    .refPhase(refPhase), .regRead(regRead), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  task automatic check(input logic [15:0] a, input logic [31:0] exp,
                       input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch reg %h exp %h seen %h", a, exp, seen);
    end
  endtask : check
  task automatic rdChk(input logic [15:0] a, input logic [31:0] exp);
    @(negedge mclk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge mclk);
    regRead = 1'b0;
    check(a, exp, regRdata);
  endtask : rdChk
  task automatic regWr(input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge mclk);
    regWrite = 1'b0;
  endtask : regWr
  task automatic checkUnit(input int u);
    regWr(etsr_pkg::OFF_UNIT_INDEX, u << 8);
    rdChk(etsr_pkg::OFF_S7_PHASE, e7p[u]);
    rdChk(etsr_pkg::OFF_S8_NSEDGE, e8n[u]);
    rdChk(etsr_pkg::OFF_S8_SECONDS, e8s[u]);
    rdChk(etsr_pkg::OFF_S8_PHASE, e8p[u]);
  endtask : checkUnit
  // capture, then move the time away so late sampling shows
  task automatic cap(input int u, input logic lvl, input logic [3:0] ph,
                     input logic s7, input logic en,
                     input logic [31:0] s, input logic [29:0] ns);
    @(negedge mclk);
    refPhase = ph;
    timeSeconds = s;
    timeNanoseconds = ns;
    captureToSeventh[u] = s7;
    eventEnable[u] = en;
    i_src.setPin(u, lvl);
    repeat (6) @(negedge mclk);
    timeSeconds = ~s;
    timeNanoseconds = ~ns;
    refPhase = ~ph;
    if (en && s7) e7p[u] = {29'h0000_0000, 3'(ph >> 1)};
    else if (en) begin
      e8n[u] = {1'b0, lvl, ns};
      e8s[u] = s;
      e8p[u] = {29'h0000_0000, 3'(ph >> 1)};
    end
  endtask : cap
  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    checkUnit(0);
    checkUnit(1);
    rdChk(16'h0100, 32'h0000_0000);
    regWr(etsr_pkg::OFF_UNIT_INDEX, 32'hffff_ffff);
    rdChk(etsr_pkg::OFF_UNIT_INDEX, 32'h0000_0100);
    regWr(etsr_pkg::OFF_S8_SECONDS, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) begin
      cap(0, ~i[0], 4'(i + 2), 1'b0, 1'b1, i * 32'h1111_1111,
          30'h3fff_ffff ^ 30'(i));
      cap(1, ~i[0], 4'(7 - i), i == 5, i != 3, 32'h8000_0001 + i,
          30'h0000_0100 << i);
      checkUnit(0);
      checkUnit(1);
    end
    // reset in mid-run clears every sample and the pointer
    @(negedge mclk);
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    e7p = '{default: 32'h0000_0000};
    e8n = '{default: 32'h0000_0000};
    e8s = '{default: 32'h0000_0000};
    e8p = '{default: 32'h0000_0000};
    rdChk(etsr_pkg::OFF_UNIT_INDEX, 32'h0000_0000);
    checkUnit(1);
    checkUnit(0);
    stop_test();
  end
endmodule : etsr_readout_test
`default_nettype wire
